// ===== rtl/psa_arbiter.v
// Segment arbiter with its control and status register file.
// Request, frame and segment clock pins are asynchronous and synchronised
// here; host, hub and CPU side signals share core_clk.
`timescale 1ns/100ps
`default_nettype none
`include "psa_regs.vh"

module psa_arbiter #(
  parameter [17:0] TMO1_CYC  = `PSA_TMO1_US * `PSA_CLK_MHZ,
  parameter [17:0] TMO4_CYC  = `PSA_TMO4_US * `PSA_CLK_MHZ,
  parameter [17:0] TMO16_CYC = `PSA_TMO16_US * `PSA_CLK_MHZ,
  parameter        DRATE_CAP = 1'b0
) (
  input  wire       core_clk,
  input  wire       nrst,
  input  wire [7:0] cfg_addr,
  input  wire       cfg_wr,
  input  wire       cfg_rd,
  input  wire [7:0] cfg_wdata,
  output reg  [7:0] cfg_rdata,
  input  wire       pci_clk,
  input  wire [6:0] req_n,
  input  wire       frame_n,
  output wire [6:0] gnt_n,
  input  wire       internal_hub_request,
  output wire       hub_grant,
  input  wire       cpu_request,
  output wire       cpu_grant,
  input  wire       host_read_req,
  input  wire       seg_fifo_empty,
  input  wire       master_write_pending,
  input  wire       ext_read_block_en,
  output wire       host_read_hold,
  input  wire       upstream_read_pending,
  output reg        read_fifo_timeout,
  input  wire       south_msg_direct_en,
  output wire       msg_direct,
  output wire       seg_read_no_pass,
  output wire       audio_read_no_pass,
  output wire       intr_blocks_audio_wr,
  output wire       flash_high_priority,
  output wire [3:0] monitor_sel,
  output wire       debug_group,
  output wire [5:0] read_pass_en,
  output wire       audio_controller_off,
  output wire       peer_cap_writable,
  output wire [3:0] clk_free_run,
  output wire       prefetch_two_lines,
  input  wire       seg_cycle_active,
  input  wire       seg_fifo_held,
  output wire       seg_clk_en
);

  localparam ST_IDLE = 3'b001;
  localparam ST_MAST = 3'b010;
  localparam ST_CPU  = 3'b100;

  // Round-robin search starting just after the last owner
  function [3:0] rr_pick;
    input [7:0] req;
    input [2:0] last;
    integer     i;
    reg   [2:0] idx;
    begin
      rr_pick = 4'h0;
      idx = 3'h0;
      for (i = 7; i >= 0; i = i - 1) begin
        idx = last + i[2:0] + 3'h1;
        if (req[idx]) begin
          rr_pick = {1'b1, idx};
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [8:0] sync1_r;
  reg [8:0] sync2_r;
  reg       pclk_d_r;
  reg       frame_d_r;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r   <= 9'h1ff;
      sync2_r   <= 9'h1ff;
      pclk_d_r  <= 1'b1;
      frame_d_r <= 1'b1;
    end else begin
      sync1_r   <= {pci_clk, frame_n, req_n};
      sync2_r   <= sync1_r;
      pclk_d_r  <= sync2_r[8];
      frame_d_r <= sync2_r[7];
    end
  end

  wire [7:0] req_v      = {internal_hub_request, ~sync2_r[6:0]};
  wire       pclk_rise  = sync2_r[8] & ~pclk_d_r;
  wire       frame_fall = ~sync2_r[7] & frame_d_r;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] arb1_r;
  reg [7:0] arb2_r;
  reg [7:0] misc_r;
  reg [7:0] pad_r;
  reg [7:0] odly_r;
  reg [7:0] cap_r;
  reg [7:0] msg_r;
  reg [7:0] order_r;
  reg [7:0] flash_r;
  reg [7:0] mon_r;
  reg [7:0] rpw_r;
  reg [7:0] audio_r;
  reg [7:0] dcc1_r;
  reg [7:0] dcc3_r;
  reg [7:0] segclk_r;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      arb1_r   <= 8'h00;
      arb2_r   <= 8'h00;
      misc_r   <= 8'h00;
      pad_r    <= 8'h00;
      odly_r   <= 8'h00;
      cap_r    <= 8'h00;
      msg_r    <= `PSA_RST_MSG;
      order_r  <= 8'h00;
      flash_r  <= 8'h00;
      mon_r    <= 8'h00;
      rpw_r    <= 8'h00;
      audio_r  <= 8'h00;
      dcc1_r   <= `PSA_RST_DCC1;
      dcc3_r   <= `PSA_RST_DCC3;
      segclk_r <= `PSA_RST_SEGCLK;
    end else if (cfg_wr) begin
      case (cfg_addr)
        `PSA_OFS_ARB1:   arb1_r   <= cfg_wdata & `PSA_MSK_ARB1;
        `PSA_OFS_ARB2:   arb2_r   <= cfg_wdata & `PSA_MSK_ARB2;
        `PSA_OFS_MISC:   misc_r   <= cfg_wdata & `PSA_MSK_MISC;
        `PSA_OFS_PAD:    pad_r    <= cfg_wdata & `PSA_MSK_PAD;
        `PSA_OFS_ODLY:   odly_r   <= cfg_wdata;
        `PSA_OFS_CAP:    cap_r    <= cfg_wdata;
        `PSA_OFS_MSG:    msg_r    <= cfg_wdata & `PSA_MSK_MSG;
        `PSA_OFS_ORDER:  order_r  <= cfg_wdata & `PSA_MSK_ORDER;
        `PSA_OFS_FLASH:  flash_r  <= cfg_wdata & `PSA_MSK_FLASH;
        `PSA_OFS_MON:    mon_r    <= cfg_wdata & `PSA_MSK_MON;
        `PSA_OFS_RPW:    rpw_r    <= cfg_wdata & `PSA_MSK_RPW;
        `PSA_OFS_AUDIO:  audio_r  <= cfg_wdata & `PSA_MSK_AUDIO;
        `PSA_OFS_DCC1:   dcc1_r   <= cfg_wdata & `PSA_MSK_DCC1;
        // bit 0 kept at its default
        `PSA_OFS_DCC3:   dcc3_r   <= (cfg_wdata & 8'h1e) | 8'h01;
        `PSA_OFS_SEGCLK: segclk_r <= cfg_wdata & `PSA_MSK_SEGCLK;
        default: begin
        end
      endcase
    end
  end

  // Read data; unmapped offsets read as zero
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_rd) begin
      case (cfg_addr)
        `PSA_OFS_ARB1:   cfg_rdata <= arb1_r;
        `PSA_OFS_ARB2:   cfg_rdata <= arb2_r;
        `PSA_OFS_MISC:   cfg_rdata <= misc_r;
        `PSA_OFS_PAD:    cfg_rdata <= {pad_r[7:1], DRATE_CAP};
        `PSA_OFS_ODLY:   cfg_rdata <= odly_r;
        `PSA_OFS_CAP:    cfg_rdata <= cap_r;
        `PSA_OFS_REQST:  cfg_rdata <= req_v;
        `PSA_OFS_MSG:    cfg_rdata <= msg_r;
        `PSA_OFS_ORDER:  cfg_rdata <= order_r;
        `PSA_OFS_FLASH:  cfg_rdata <= flash_r;
        `PSA_OFS_MON:    cfg_rdata <= mon_r;
        `PSA_OFS_RPW:    cfg_rdata <= rpw_r;
        `PSA_OFS_AUDIO:  cfg_rdata <= audio_r;
        // Latency timer enable always reads as zero
        `PSA_OFS_DCC1:   cfg_rdata <= dcc1_r & 8'hdf;
        `PSA_OFS_DCC3:   cfg_rdata <= dcc3_r;
        `PSA_OFS_SEGCLK: cfg_rdata <= segclk_r;
        default:         cfg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Arbiter
  // ----------------------------------------------------------------
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [2:0] owner_r;
  reg [2:0] owner_nxt;
  reg [1:0] rot_cnt_r;
  reg [1:0] rot_cnt_nxt;
  reg [6:0] slice_r;

  wire [1:0] rot_sel  = arb2_r[5:4];
  wire [1:0] remap    = arb2_r[3:2];
  wire       park_en  = arb2_r[`PSA_B_PARK];
  wire       hp_en    = arb2_r[`PSA_B_HP];
  wire       frame_md = arb1_r[`PSA_B_ARBMODE];
  wire [2:0] tmo_sel  = arb1_r[2:0];

  // physical line acting as request four
  wire [2:0] hp_idx = (remap == 2'b01) ? 3'd0 :
                      (remap == 2'b10) ? 3'd1 : 3'd4;

  wire [7:0] others  = req_v & ~(8'h01 << owner_r);
  wire [3:0] rr      = rr_pick(req_v, owner_r);
  wire       hp_win  = hp_en & req_v[hp_idx];
  wire [3:0] pick    = hp_win ? {1'b1, hp_idx} : rr;
  // CPU insertion after N master grants
  wire       cpu_due = (rot_sel != 2'b00) & (rot_cnt_r >= rot_sel) & cpu_request;
  // Count saturates so a wrap can never cost the CPU its turn
  wire [1:0] rot_inc = (rot_cnt_r == 2'd3) ? rot_cnt_r : rot_cnt_r + 2'd1;
  wire       own_req = req_v[owner_r];

  // limit is the field times sixteen segment clocks
  wire [6:0] tmo_lim = {tmo_sel, 4'h0};
  wire       tmo_hit = (tmo_sel != 3'b000) & (slice_r >= tmo_lim);

  // request end, or frame start in frame mode
  wire       rearb   = ~own_req | (frame_md & frame_fall) | tmo_hit;

  always @* begin
    state_nxt   = state_r;
    owner_nxt   = owner_r;
    rot_cnt_nxt = rot_cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (cpu_due) begin
          state_nxt = ST_CPU;
        end else if (pick[3]) begin
          state_nxt   = ST_MAST;
          owner_nxt   = pick[2:0];
          rot_cnt_nxt = rot_inc;
        end
      end
      ST_MAST: begin
        if (rearb) begin
          if (cpu_due) begin
            state_nxt = ST_CPU;
          end else if (others != 8'h00) begin
            owner_nxt   = pick[2:0];
            rot_cnt_nxt = rot_inc;
          end else if (own_req) begin
            owner_nxt = owner_r;
          end else if (!park_en) begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_CPU: begin
        rot_cnt_nxt = 2'd0;
        if (!cpu_request) begin
          state_nxt = pick[3] ? ST_MAST : ST_IDLE;
          owner_nxt = pick[3] ? pick[2:0] : owner_r;
          if (pick[3]) begin
            rot_cnt_nxt = 2'd1;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r   <= ST_IDLE;
      owner_r   <= 3'd7;
      rot_cnt_r <= 2'd0;
      slice_r   <= 7'd0;
    end else begin
      state_r   <= state_nxt;
      owner_r   <= owner_nxt;
      rot_cnt_r <= rot_cnt_nxt;
      // Slice counts only while others wait on the current owner
      if (state_nxt != ST_MAST || owner_nxt != owner_r || others == 8'h00) begin
        slice_r <= 7'd0;
      end else if (pclk_rise && slice_r != 7'h7f) begin
        slice_r <= slice_r + 7'd1;
      end
    end
  end

  wire [7:0] gnt_v = (state_r == ST_MAST) ? (8'h01 << owner_r) : 8'h00;
  assign gnt_n     = ~gnt_v[6:0];
  assign hub_grant = gnt_v[7];
  assign cpu_grant = (state_r == ST_CPU);

  // ----------------------------------------------------------------
  // Read FIFO timer
  // ----------------------------------------------------------------
  reg [17:0] rd_tmr_r;
  reg        rd_fired_r;

  wire [17:0] rd_lim = (misc_r[4:3] == 2'b01) ? TMO1_CYC :
                       (misc_r[4:3] == 2'b10) ? TMO4_CYC : TMO16_CYC;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_tmr_r          <= 18'h00000;
      rd_fired_r        <= 1'b0;
      read_fifo_timeout <= 1'b0;
    end else begin
      read_fifo_timeout <= 1'b0;
      if (!upstream_read_pending || misc_r[4:3] == 2'b00) begin
        rd_tmr_r   <= 18'h00000;
        rd_fired_r <= 1'b0;
      end else if (!rd_fired_r) begin
        if (rd_tmr_r >= rd_lim - 18'h00001) begin
          read_fifo_timeout <= 1'b1;
          rd_fired_r        <= 1'b1;
        end else begin
          rd_tmr_r <= rd_tmr_r + 18'h00001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  // hold host read on FIFO not empty or pending writes
  assign host_read_hold = host_read_req & (misc_r[`PSA_B_FIFOSEL] ? ~seg_fifo_empty :
                          (ext_read_block_en & master_write_pending));
  assign msg_direct = south_msg_direct_en & msg_r[`PSA_B_MSGDIR];
  assign seg_read_no_pass     = order_r[2];
  assign audio_read_no_pass   = order_r[1];
  assign intr_blocks_audio_wr = order_r[0];
  assign flash_high_priority  = flash_r[0];
  assign monitor_sel = (mon_r[5:2] == 4'h7 || mon_r[5:2] > 4'hc) ? 4'h0 : mon_r[5:2];
  assign debug_group = mon_r[1];
  assign read_pass_en = rpw_r[6:1];
  assign audio_controller_off = audio_r[`PSA_B_AUDDIS];
  assign peer_cap_writable    = audio_r[`PSA_B_PEERWR];
  assign clk_free_run = dcc3_r[4:1];
  assign prefetch_two_lines = segclk_r[`PSA_B_PREFETCH];
  // clock held to cycle end or FIFO release
  assign seg_clk_en = clk_free_run[2] | seg_cycle_active |
                      (~segclk_r[`PSA_B_GATE] & seg_fifo_held);

endmodule // psa_arbiter

`default_nettype wire

// ===== rtl/psa_regs.vh
// Register offsets, field positions, reset values and timing counts
// for the segment arbitration and control block.
// Assumes an 8-bit configuration port whose addresses are the printed offsets.
// How it works
// - Parking keeps last master granted when idle
// - Rotation field inserts CPU grant every N
// - Remap field picks request zero or one
// - Remapped request four becomes high priority
// - Host read held on FIFO or writes
// - Read FIFO timer: none, 1/4/16 ms
// - Fixed read-only double-rate support bit
// - Per-requester double-rate capability bits
// - Live request line status, read only
// - Interrupt messages direct when both bits set
// - Segment upstream reads wait for writes
// - Audio upstream reads wait for writes
// - Interrupt cycle blocks audio upstream writes
// - Flash interface priority low or high
// - Monitor select code and debug group
// - Per-source read passes write enables
// - Audio disable and peer bridge writability
// - Four clocks dynamic or free running
// - Prefetch allocation one or two lines
// - Segment clock held to FIFO or cycle
// - Arbitrate at request end or frame
// - Master timeout in units of sixteen
`ifndef PSA_REGS_VH
`define PSA_REGS_VH

`define PSA_OFS_ARB1      8'h75
`define PSA_OFS_ARB2      8'h76
`define PSA_OFS_MISC      8'h77
`define PSA_OFS_PAD       8'h78
`define PSA_OFS_ODLY      8'h79
`define PSA_OFS_CAP       8'h7a
`define PSA_OFS_REQST     8'h7b
`define PSA_OFS_MSG       8'h7c
`define PSA_OFS_ORDER     8'h80
`define PSA_OFS_FLASH     8'h81
`define PSA_OFS_MON       8'h82
`define PSA_OFS_RPW       8'h84
`define PSA_OFS_AUDIO     8'hd1
`define PSA_OFS_DCC1      8'he0
`define PSA_OFS_DCC3      8'he2
`define PSA_OFS_SEGCLK    8'he3

// Writable bit masks; reserved bits read as zero
`define PSA_MSK_ARB1      8'hff
`define PSA_MSK_ARB2      8'hfd
`define PSA_MSK_MISC      8'h58
`define PSA_MSK_PAD       8'hfc
`define PSA_MSK_MSG       8'h02
`define PSA_MSK_ORDER     8'h07
`define PSA_MSK_FLASH     8'h01
`define PSA_MSK_MON       8'h3e
`define PSA_MSK_RPW       8'h7e
`define PSA_MSK_AUDIO     8'h0c
`define PSA_MSK_DCC1      8'he0
`define PSA_MSK_DCC3      8'h1f
`define PSA_MSK_SEGCLK    8'hfe

`define PSA_RST_MSG       8'h02
`define PSA_RST_DCC1      8'h40
`define PSA_RST_DCC3      8'h1f
`define PSA_RST_SEGCLK    8'h6e

// Field positions
`define PSA_B_ARBMODE     7
`define PSA_B_PARK        6
`define PSA_B_HP          0
`define PSA_B_FIFOSEL     6
`define PSA_B_MSGDIR      1
`define PSA_B_AUDDIS      2
`define PSA_B_PEERWR      3
`define PSA_B_PREFETCH    7
`define PSA_B_GATE        6

// Timing
`define PSA_CLK_MHZ       10
`define PSA_TMO1_US       1000
`define PSA_TMO4_US       4000
`define PSA_TMO16_US      16000
`define PSA_TSLICE        16

`endif

// ===== tb/psa_master_model.sv
// Behavioural bus masters on the far side of the segment arbiter.
// Assumes want selects which request lines the masters pull active.
`timescale 1ns/100ps
`default_nettype none
module psa_master_model (
  input  wire logic [6:0] want,
  input  wire logic [6:0] gnt_n,
  output logic            pci_clk,
  output logic [6:0]      req_n,
  output logic            frame_n
);
  // Segment clock runs free, out of phase with the core clock
  initial begin
    pci_clk = 1'b0;
    #137;
    forever #400 pci_clk = ~pci_clk;
  end
  // Released lines idle high through their pull-ups
  initial req_n = 7'h7f;
  initial frame_n = 1'b1;
  // Pins move on segment clock edges only, as a real master would
  always @(posedge pci_clk) begin
    req_n <= ~want;
    frame_n <= ~|(want & ~gnt_n);
  end
endmodule // psa_master_model
`default_nettype wire

// ===== tb/psa_arbiter_sva.sv
// Port-level checks for the segment arbiter.
// Assumes one core_clk domain, nrst asynchronous and active low.
`timescale 1ns/100ps
`default_nettype none
module psa_arbiter_sva (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic [6:0] gnt_n,
  input wire logic       hub_grant,
  input wire logic       cpu_grant,
  input wire logic       cpu_request,
  input wire logic       internal_hub_request,
  input wire logic       host_read_req,
  input wire logic       seg_fifo_empty,
  input wire logic       master_write_pending,
  input wire logic       ext_read_block_en,
  input wire logic       host_read_hold,
  input wire logic       upstream_read_pending,
  input wire logic       read_fifo_timeout,
  input wire logic       south_msg_direct_en,
  input wire logic       msg_direct,
  input wire logic [3:0] clk_free_run,
  input wire logic       seg_cycle_active,
  input wire logic       seg_clk_en
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  sequence s_hub_rise;
    !hub_grant ##1 hub_grant;
  endsequence
  sequence s_cpu_rise;
    !cpu_grant ##1 cpu_grant;
  endsequence
  sequence s_tmo_rise;
    !read_fifo_timeout ##1 read_fifo_timeout;
  endsequence
  a_grant_onehot: assert property ($onehot0({~gnt_n, hub_grant, cpu_grant}))
    else $error("more than one grant active");
  a_hub_grant_cause: assert property (s_hub_rise |-> $past(internal_hub_request))
    else $error("hub granted without a request");
  a_cpu_grant_cause: assert property (s_cpu_rise |-> $past(cpu_request))
    else $error("cpu granted without a request");
  a_tmo_one_pulse: assert property (s_tmo_rise |=> !read_fifo_timeout)
    else $error("read timer pulse too long");
  a_tmo_cause: assert property (read_fifo_timeout |-> $past(upstream_read_pending))
    else $error("read timer fired with nothing pending");
  a_hold_needs_req: assert property (host_read_hold |-> host_read_req)
    else $error("host read held with no read");
  a_hold_write_path: assert property (host_read_hold && seg_fifo_empty |->
    ext_read_block_en && master_write_pending)
    else $error("host read held on empty fifo without writes");
  a_msg_needs_en: assert property (msg_direct |-> south_msg_direct_en)
    else $error("direct messages without south enable");
  a_free_run_clk: assert property (clk_free_run[2] |-> seg_clk_en)
    else $error("free running segment clock stopped");
  a_cycle_keeps_clk: assert property (seg_cycle_active |-> seg_clk_en)
    else $error("segment clock stopped inside a cycle");
endmodule // psa_arbiter_sva
bind psa_arbiter psa_arbiter_sva psa_arbiter_sva_i (.*);
`default_nettype wire

// ===== tb/psa_arbiter_test.sv
// Self-checking bench: registers, request status, holds, clocks, timer, grants.
// Assumes the master model drives the pins and the checker is bound.
`timescale 1ns/100ps
`default_nettype none
module psa_arbiter_test;
  logic       core_clk = 1'b0, nrst = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0;
  logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00;
  logic       internal_hub_request = 1'b0, cpu_request = 1'b0, host_read_req = 1'b0;
  logic       seg_fifo_empty = 1'b0, master_write_pending = 1'b0, ext_read_block_en = 1'b0;
  logic       upstream_read_pending = 1'b0, south_msg_direct_en = 1'b1;
  logic       seg_cycle_active = 1'b0, seg_fifo_held = 1'b0;
  logic [6:0] want = 7'h00;
  wire        pci_clk, frame_n, hub_grant, cpu_grant, host_read_hold, read_fifo_timeout;
  wire        msg_direct, seg_read_no_pass, audio_read_no_pass, intr_blocks_audio_wr;
  wire        flash_high_priority, debug_group, audio_controller_off, peer_cap_writable;
  wire        prefetch_two_lines, seg_clk_en;
  wire [7:0]  cfg_rdata;
  wire [6:0]  req_n, gnt_n;
  wire [5:0]  read_pass_en;
  wire [3:0]  monitor_sel, clk_free_run;
  int         failures = 0;
  int         checks_done = 0;
  logic [7:0] ofs [17] = '{8'h75, 8'h76, 8'h77, 8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h80,
                           8'h81, 8'h82, 8'h84, 8'hd1, 8'he0, 8'he2, 8'he3, 8'h90};
  logic [7:0] rst [17] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00,
                           8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h1f, 8'h6e, 8'h00};
  logic [7:0] ffv [17] = '{8'hff, 8'hfd, 8'h58, 8'hfc, 8'hff, 8'hff, 8'h00, 8'h02, 8'h07,
                           8'h01, 8'h3e, 8'h7e, 8'h0c, 8'hc0, 8'h1f, 8'hfe, 8'h00};

  always #50 core_clk = ~core_clk;
  // Short timer limits keep the run brief
  psa_arbiter #(.TMO1_CYC(18'd20), .TMO4_CYC(18'd40), .TMO16_CYC(18'd80)) psa_arbiter_i (.*);
  psa_master_model psa_master_model_i (.*);

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge core_clk);
    cfg_rd <= 1'b0;
    #1 check($sformatf("register %h", a), cfg_rdata, e);
  endtask
  // Bounded wait for the grants to go busy or idle
  task automatic wait_gnt(input logic idle);
    for (int n = 0; n < 40 && ((gnt_n === 7'h7f) !== idle); n++) begin
      @(posedge core_clk);
      #1;
    end
  endtask
  task automatic t_regs;
    for (int j = 0; j < 17; j++) rd(ofs[j], rst[j]);
    for (int v = 0; v < 2; v++) begin
      for (int j = 0; j < 17; j++) wr(ofs[j], v ? 8'h00 : 8'hff);
      for (int j = 0; j < 17; j++) rd(ofs[j], v ? {7'h0, ofs[j] == 8'he2} : ffv[j]);
      check("pass bits", {read_pass_en, flash_high_priority, prefetch_two_lines},
            v ? 8'h00 : 8'hff);
      check("control bits", {seg_read_no_pass, audio_read_no_pass, intr_blocks_audio_wr,
            audio_controller_off, peer_cap_writable, debug_group, msg_direct, 1'b1},
            v ? 8'h01 : 8'hff);
      check("clock bits", {monitor_sel, clk_free_run}, v ? 8'h00 : 8'h0f);
    end
  endtask
  task automatic t_monitor;
    for (int c = 0; c < 16; c++) begin
      wr(8'h82, 8'(c << 2));
      @(posedge core_clk);
      #1 check("monitor", {4'h0, monitor_sel}, (c == 7 || c > 12) ? 8'h00 : 8'(c));
    end
  endtask
  task automatic t_status;
    @(posedge core_clk);
    want <= 7'h55;
    internal_hub_request <= 1'b1;
    repeat (20) @(posedge core_clk);
    #1 check("hub grant", {7'h0, hub_grant}, 8'h01);
    rd(8'h7b, 8'hd5);
    @(posedge core_clk);
    want <= 7'h00;
    internal_hub_request <= 1'b0;
    repeat (20) @(posedge core_clk);
    rd(8'h7b, 8'h00);
  endtask
  task automatic t_hold;
    logic [4:0] b;
    for (int i = 0; i < 32; i++) begin
      b = 5'(i);
      if (b[3:0] == 4'h0) wr(8'h77, {1'b0, b[4], 6'h00});
      @(posedge core_clk);
      host_read_req <= b[3];
      ext_read_block_en <= b[2];
      master_write_pending <= b[1];
      seg_fifo_empty <= b[0];
      @(posedge core_clk);
      #1 check("read hold", {7'h0, host_read_hold},
               {7'h0, b[3] & (b[4] ? ~b[0] : b[2] & b[1])});
    end
  endtask
  task automatic t_segclk;
    logic [3:0] b;
    for (int i = 0; i < 16; i++) begin
      b = 4'(i);
      wr(8'he2, {4'h1, b[3], 3'h7});
      wr(8'he3, {1'b0, b[2], 6'h2e});
      @(posedge core_clk);
      seg_cycle_active <= b[1];
      seg_fifo_held <= b[0];
      @(posedge core_clk);
      #1 check("segment clock", {7'h0, seg_clk_en}, {7'h0, b[3] | b[1] | (~b[2] & b[0])});
    end
  endtask
  task automatic t_timer;
    int n;
    int lim;
    for (int c = 0; c < 4; c++) begin
      lim = 10 << c;
      wr(8'h77, 8'(c << 3));
      @(posedge core_clk);
      upstream_read_pending <= 1'b1;
      for (n = 0; n < 200 && read_fifo_timeout !== 1'b1; n++) begin
        @(posedge core_clk);
        #1;
      end
      check("read timer", {7'h0, c == 0 ? n == 200 : n >= lim - 2 && n <= lim + 3}, 8'h01);
      @(posedge core_clk);
      upstream_read_pending <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask
  task automatic t_priority;
    logic [2:0] w;
    for (int c = 0; c < 4; c++) begin
      w = (c == 1) ? 3'd0 : (c == 2) ? 3'd1 : 3'd4;
      wr(8'h76, 8'(c << 2) | 8'h01);
      @(posedge core_clk);
      want <= 7'h1b;
      wait_gnt(1'b0);
      check("priority grant", {1'b0, gnt_n}, {1'b0, ~(7'h01 << w)});
      @(posedge core_clk);
      want <= 7'h00;
      wait_gnt(1'b1);
    end
  endtask
  task automatic t_parking;
    for (int p = 0; p < 2; p++) begin
      wr(8'h76, p ? 8'h40 : 8'h00);
      @(posedge core_clk);
      want <= 7'h04;
      wait_gnt(1'b0);
      check("single grant", {1'b0, gnt_n}, 8'h7b);
      @(posedge core_clk);
      want <= 7'h00;
      repeat (30) @(posedge core_clk);
      #1 check("parked grant", {1'b0, gnt_n}, p ? 8'h7b : 8'h7f);
    end
  endtask
  task automatic t_rotation;
    for (int r = 0; r < 2; r++) begin
      wr(8'h76, r ? 8'h10 : 8'h00);
      wait_gnt(1'b1);
      @(posedge core_clk);
      want <= 7'h04;
      wait_gnt(1'b0);
      check("master before cpu", {1'b0, gnt_n}, 8'h7b);
      @(posedge core_clk);
      cpu_request <= 1'b1;
      want <= 7'h00;
      wait_gnt(1'b1);
      check("cpu inserted", {7'h0, cpu_grant}, {7'h0, r == 1});
      @(posedge core_clk);
      cpu_request <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1 check("cpu released", {7'h0, cpu_grant}, 8'h00);
    end
  endtask
  // Timeout of 16 segment clocks, then frame-based rearbitration
  task automatic t_slice;
    logic [6:0] g;
    int n;
    for (int m = 0; m < 2; m++) begin
      wr(8'h75, m ? 8'h80 : 8'h01);
      @(posedge core_clk);
      want <= 7'h03;
      wait_gnt(1'b0);
      g = gnt_n;
      for (n = 0; n < 200 && gnt_n === g; n++) begin
        @(posedge core_clk);
        #1;
      end
      check("regrant time", {7'h0, m ? n < 16 : n >= 116 && n <= 136}, 8'h01);
      check("next master", {1'b0, gnt_n}, {1'b0, g ^ 7'h03});
      @(posedge core_clk);
      want <= 7'h00;
      wait_gnt(1'b1);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    t_regs;
    t_monitor;
    t_status;
    t_hold;
    t_segclk;
    t_timer;
    t_priority;
    t_parking;
    t_rotation;
    t_slice;
    tally_and_finish;
  end
  // Whole run needs under two thousand cycles; this limit only cuts a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    tally_and_finish;
  end
endmodule // psa_arbiter_test
`default_nettype wire
